// ===== inc/synth_cfg_defines.svh
/*
 * register offsets, field positions and reset values of the synthesizer
 * sysref, channel divider and ramp configuration bank.
 * assumes a 7-bit word address and 16-bit register words.
 */
`ifndef SYNTH_CFG_DEFINES_SVH
`define SYNTH_CFG_DEFINES_SVH

`define ADDR_MODE 7'h47
`define ADDR_RATE 7'h48
`define ADDR_DLY_A 7'h49
`define ADDR_DLY_B 7'h4A
`define ADDR_CHANNEL_DIVISION_CODE 7'h4B
`define ADDR_RECAL 7'h4E
`define ADDR_THR_MID 7'h4F
`define ADDR_THR_LOW 7'h50
`define ADDR_UP_MSB 7'h51
`define ADDR_UP_MID 7'h52
`define ADDR_UP_LOW 7'h53
`define ADDR_LO_MSB 7'h54
`define ADDR_LO_MID 7'h55
`define ADDR_LO_LOW 7'h56

`define PRE_MSB 7
`define PRE_LSB 5
`define PULSE_BIT 4
`define EN_BIT 3
`define REPEAT_BIT 2
`define MODE_ONE_BIT 0
`define DIV_MSB 10
`define W_LO_MSB 5
`define W_HI_LSB 6
`define W_HI_MSB 11
`define BURST_LSB 12
`define BURST_MSB 15
`define CHANNEL_DIVISION_CODE_LSB 6
`define CHANNEL_DIVISION_CODE_MSB 10
`define CHANNEL_DIVISION_CODE_ONE_BIT 11
`define THR_TOP_BIT 11
`define QUICK_BIT 9
`define CAP_LSB 1
`define CAP_MSB 8
`define RECAL_ONE_BIT 0

`define PRE_RESET 3'h4
`define PRE_DIV2 3'h2
`define PRE_DIV4 3'h4
`define W1_RESET 6'h3F
`define CHANNEL_DIVISION_CODE_FIRST_RSVD 5'h12
`define CAP_MAX 8'hB7
`define DIV_OFFSET 13'h0004

`endif

// ===== inc/synth_cfg_pkg.sv
/*
 * types shared by the configuration bank.
 * assumes the defines header is compiled alongside.
 */
package synth_cfg_pkg;
   typedef logic [15:0] reg_word_type;
   typedef logic [6:0] reg_addr_type;
   typedef enum logic [2:0] {
      PRESCALE_DIV2 = 3'h2,
      PRESCALE_DIV4 = 3'h4
   } prescale_type;
endpackage

// ===== design/synth_sysref_ramp_config_regs.sv
/*
 * sysref, channel divider and ramp calibration configuration bank with
 * the decode and ramp limiting logic that these fields steer.
 * assumes the register port, ramp offset and last-calibration inputs come
 * from logic on i_clock, so none of them is synchronised here.
 */
// Implementation choice: strobed register access.
// Summary of operation
// [RULE_01] prescale code 2 divides by two, 4 by four, others invalid; reset 4
// [RULE_02] pulse bit in master operation gives sysref bursts, clear gives continuous
// [RULE_03] repeat bit 0 master, 1 repeater; enable bit turns sysref on
// [RULE_04] sysref rate divides input by twice divisor plus four
// [RULE_05] software keeps two delay weights zero, other two sum 63
// [RULE_06] burst length field sets pulses per burst in master pulser operation
// [RULE_07] channel code 0..17 maps to division ratios, 18..31 reserved
// [RULE_08] 33-bit threshold sets ramp frequency move before recalibration
// [RULE_09] fast recalibration starts from last core, cap code and bias
// [RULE_10] start cap code seeds calibration, kept within 0 to 183
// [RULE_11] ramp limits and threshold act only while ramp enable is 1
// [RULE_12] ramp never goes above the 33-bit upper limit
// [RULE_13] ramp never goes below the two's-complement lower limit
// [RULE_14] software writes reserved bits with their fixed constants
`timescale 1ns/1ps
`include "synth_cfg_defines.svh"
`default_nettype none

module synth_sysref_ramp_config_regs #(
   parameter int CORE_W = 3,
   parameter int BIAS_W = 9,
   parameter logic [2:0] DEFAULT_CORE = 3'h0,
   parameter logic [8:0] DEFAULT_BIAS = 9'h000
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [6:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_ramp_enable,
   input wire logic signed [32:0] i_ramp_offset,
   input wire logic [CORE_W-1:0] i_last_core,
   input wire logic [7:0] i_last_cap,
   input wire logic [BIAS_W-1:0] i_last_bias,
   output logic [2:0] o_prescale_ratio,
   output logic o_prescale_invalid,
   output logic o_sysref_master,
   output logic o_sysref_repeater,
   output logic o_sysref_burst,
   output logic [3:0] o_sysref_burst_length,
   output logic [12:0] o_sysref_ratio,
   output logic [23:0] o_delay_weights,
   output logic [9:0] o_channel_division_code_ratio,
   output logic o_channel_division_code_reserved,
   output logic [32:0] o_recal_threshold,
   output logic o_recal_due,
   output logic signed [32:0] o_ramp_offset,
   output logic o_at_upper,
   output logic o_at_lower,
   output logic [CORE_W-1:0] o_cal_core,
   output logic [7:0] o_cal_cap,
   output logic [BIAS_W-1:0] o_cal_bias
);

   // ratio per channel code; reserved codes give zero so a bad code cannot divide
   localparam logic [9:0] CHANNEL_DIVISION_CODE_TABLE [`CHANNEL_DIVISION_CODE_FIRST_RSVD] = '{10'h002, 10'h004, 10'h006,
      10'h008, 10'h00C, 10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h048, 10'h060,
      10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300};
   function automatic logic [9:0] channel_division_code_ratio(input logic [4:0] code);
      return (code < `CHANNEL_DIVISION_CODE_FIRST_RSVD) ? CHANNEL_DIVISION_CODE_TABLE[code] : 10'h000;
   endfunction

   function automatic logic wr_hit(input logic wr, input logic [6:0] a, input logic [6:0] o);
      return wr && (a == o);
   endfunction

   logic [2:0] prescale_q;
   logic pulse_q, en_q, repeat_q;
   logic [10:0] div_q;
   logic [5:0] w1_q, w2_q, w3_q, w4_q;
   logic [3:0] burst_q;
   logic [4:0] channel_division_code_q;
   logic thr_top_q, quick_q;
   logic [7:0] cap_q;
   logic [31:0] thr_q;
   logic [32:0] up_q, lo_q;
   logic signed [32:0] anchor_q;
   logic [15:0] rdata_d;
   // sysref mode and rate fields
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         prescale_q <= `PRE_RESET; // [RULE_01]
         pulse_q <= 1'b0;
         en_q <= 1'b0;
         repeat_q <= 1'b0;
      end else if (wr_hit(i_wr, i_addr, `ADDR_MODE)) begin
         prescale_q <= i_wdata[`PRE_MSB:`PRE_LSB];
         pulse_q <= i_wdata[`PULSE_BIT];
         en_q <= i_wdata[`EN_BIT];
         repeat_q <= i_wdata[`REPEAT_BIT];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         div_q <= 11'h000;
      end else if (wr_hit(i_wr, i_addr, `ADDR_RATE)) begin
         div_q <= i_wdata[`DIV_MSB:0];
      end
   end
   // weights are stored as written; keeping the pairing legal is up to software
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         w1_q <= `W1_RESET; // [RULE_05]
         w2_q <= 6'h00;
         w3_q <= 6'h00;
         w4_q <= 6'h00;
         burst_q <= 4'h0;
      end else begin
         if (wr_hit(i_wr, i_addr, `ADDR_DLY_A)) begin
            w1_q <= i_wdata[`W_LO_MSB:0];
            w2_q <= i_wdata[`W_HI_MSB:`W_HI_LSB];
         end
         if (wr_hit(i_wr, i_addr, `ADDR_DLY_B)) begin
            w3_q <= i_wdata[`W_LO_MSB:0];
            w4_q <= i_wdata[`W_HI_MSB:`W_HI_LSB];
            burst_q <= i_wdata[`BURST_MSB:`BURST_LSB];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         channel_division_code_q <= 5'h00;
      end else if (wr_hit(i_wr, i_addr, `ADDR_CHANNEL_DIVISION_CODE)) begin
         channel_division_code_q <= i_wdata[`CHANNEL_DIVISION_CODE_MSB:`CHANNEL_DIVISION_CODE_LSB];
      end
   end
   // calibration control and threshold words
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         thr_top_q <= 1'b0;
         quick_q <= 1'b0;
         cap_q <= 8'h00;
         thr_q <= 32'h0000_0000;
      end else begin
         if (wr_hit(i_wr, i_addr, `ADDR_RECAL)) begin
            thr_top_q <= i_wdata[`THR_TOP_BIT];
            quick_q <= i_wdata[`QUICK_BIT];
            cap_q <= i_wdata[`CAP_MSB:`CAP_LSB];
         end
         if (wr_hit(i_wr, i_addr, `ADDR_THR_MID)) thr_q[31:16] <= i_wdata;
         if (wr_hit(i_wr, i_addr, `ADDR_THR_LOW)) thr_q[15:0] <= i_wdata;
      end
   end
   // limits: words land independently, so a partial update is visible between writes
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         up_q <= 33'h0_0000_0000;
         lo_q <= 33'h0_0000_0000;
      end else begin
         if (wr_hit(i_wr, i_addr, `ADDR_UP_MSB)) up_q[32] <= i_wdata[0];
         if (wr_hit(i_wr, i_addr, `ADDR_UP_MID)) up_q[31:16] <= i_wdata;
         if (wr_hit(i_wr, i_addr, `ADDR_UP_LOW)) up_q[15:0] <= i_wdata;
         if (wr_hit(i_wr, i_addr, `ADDR_LO_MSB)) lo_q[32] <= i_wdata[0];
         if (wr_hit(i_wr, i_addr, `ADDR_LO_MID)) lo_q[31:16] <= i_wdata;
         if (wr_hit(i_wr, i_addr, `ADDR_LO_LOW)) lo_q[15:0] <= i_wdata;
      end
   end
   // readback; fixed one bits read back as one whatever was written
   always_comb begin
      rdata_d = 16'h0000;
      case (i_addr)
         `ADDR_MODE: begin
            rdata_d[`PRE_MSB:`PRE_LSB] = prescale_q;
            rdata_d[`PULSE_BIT] = pulse_q;
            rdata_d[`EN_BIT] = en_q;
            rdata_d[`REPEAT_BIT] = repeat_q;
            rdata_d[`MODE_ONE_BIT] = 1'b1; // [RULE_14]
         end
         `ADDR_RATE: rdata_d[`DIV_MSB:0] = div_q;
         `ADDR_DLY_A: rdata_d[`W_HI_MSB:0] = {w2_q, w1_q};
         `ADDR_DLY_B: rdata_d = {burst_q, w4_q, w3_q};
         `ADDR_CHANNEL_DIVISION_CODE: begin
            rdata_d[`CHANNEL_DIVISION_CODE_ONE_BIT] = 1'b1; // [RULE_14]
            rdata_d[`CHANNEL_DIVISION_CODE_MSB:`CHANNEL_DIVISION_CODE_LSB] = channel_division_code_q;
         end
         `ADDR_RECAL: begin
            rdata_d[`THR_TOP_BIT] = thr_top_q;
            rdata_d[`QUICK_BIT] = quick_q;
            rdata_d[`CAP_MSB:`CAP_LSB] = cap_q;
            rdata_d[`RECAL_ONE_BIT] = 1'b1; // [RULE_14]
         end
         `ADDR_THR_MID: rdata_d = thr_q[31:16];
         `ADDR_THR_LOW: rdata_d = thr_q[15:0];
         `ADDR_UP_MSB: rdata_d[0] = up_q[32];
         `ADDR_UP_MID: rdata_d = up_q[31:16];
         `ADDR_UP_LOW: rdata_d = up_q[15:0];
         `ADDR_LO_MSB: rdata_d[0] = lo_q[32];
         `ADDR_LO_MID: rdata_d = lo_q[31:16];
         `ADDR_LO_LOW: rdata_d = lo_q[15:0];
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= i_rd ? rdata_d : 16'h0000;
      end
   end
   // sysref decode
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_prescale_ratio <= 3'h0;
         o_prescale_invalid <= 1'b0;
         o_sysref_master <= 1'b0;
         o_sysref_repeater <= 1'b0;
         o_sysref_burst <= 1'b0;
         o_sysref_burst_length <= 4'h0;
         o_sysref_ratio <= `DIV_OFFSET;
         o_delay_weights <= 24'h00_0000;
      end else begin
         case (prescale_q) // [RULE_01]
            synth_cfg_pkg::PRESCALE_DIV2: o_prescale_ratio <= `PRE_DIV2;
            synth_cfg_pkg::PRESCALE_DIV4: o_prescale_ratio <= `PRE_DIV4;
            default: o_prescale_ratio <= 3'h0;
         endcase
         o_prescale_invalid <= (prescale_q != `PRE_DIV2) && (prescale_q != `PRE_DIV4);
         o_sysref_master <= en_q && !repeat_q; // [RULE_03]
         o_sysref_repeater <= en_q && repeat_q; // [RULE_03]
         o_sysref_burst <= en_q && !repeat_q && pulse_q; // [RULE_02]
         o_sysref_burst_length <= (en_q && !repeat_q && pulse_q) ? burst_q : 4'h0; // [RULE_06]
         o_sysref_ratio <= {1'b0, div_q, 1'b0} + `DIV_OFFSET; // [RULE_04]
         o_delay_weights <= {w4_q, w3_q, w2_q, w1_q};
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_channel_division_code_ratio <= 10'h002;
         o_channel_division_code_reserved <= 1'b0;
      end else begin
         o_channel_division_code_ratio <= channel_division_code_ratio(channel_division_code_q); // [RULE_07]
         o_channel_division_code_reserved <= channel_division_code_q >= `CHANNEL_DIVISION_CODE_FIRST_RSVD; // [RULE_07]
      end
   end
   // ramp side: threshold, recalibration and limit logic is held neutral while ramping is off; the calibration seeds below follow quick_q only
   logic signed [33:0] delta;
   logic [33:0] delta_mag;
   logic over_up, under_lo, step_big;
   assign delta = {i_ramp_offset[32], i_ramp_offset} - {anchor_q[32], anchor_q};
   assign delta_mag = delta[33] ? 34'(-delta) : 34'(delta);
   assign step_big = delta_mag > {1'b0, thr_top_q, thr_q};
   assign over_up = i_ramp_offset > $signed(up_q);
   assign under_lo = i_ramp_offset < $signed(lo_q);

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_recal_threshold <= 33'h0_0000_0000;
         o_recal_due <= 1'b0;
         anchor_q <= 33'sh0_0000_0000;
      end else if (i_ramp_enable) begin
         o_recal_threshold <= {thr_top_q, thr_q}; // [RULE_08]
         o_recal_due <= step_big; // [RULE_08]
         if (step_big) anchor_q <= i_ramp_offset;
      end else begin
         o_recal_threshold <= 33'h0_0000_0000; // [RULE_11]
         o_recal_due <= 1'b0;
         anchor_q <= i_ramp_offset;
      end
   end
   // clamping only, no wrap: an upper limit below the lower one leaves upper winning
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_ramp_offset <= 33'sh0_0000_0000;
         o_at_upper <= 1'b0;
         o_at_lower <= 1'b0;
      end else if (!i_ramp_enable) begin
         o_ramp_offset <= i_ramp_offset; // [RULE_11]
         o_at_upper <= 1'b0;
         o_at_lower <= 1'b0;
      end else if (over_up) begin
         o_ramp_offset <= $signed(up_q); // [RULE_12]
         o_at_upper <= 1'b1;
         o_at_lower <= 1'b0;
      end else if (under_lo) begin
         o_ramp_offset <= $signed(lo_q); // [RULE_13]
         o_at_upper <= 1'b0;
         o_at_lower <= 1'b1;
      end else begin
         o_ramp_offset <= i_ramp_offset;
         o_at_upper <= 1'b0;
         o_at_lower <= 1'b0;
      end
   end
   // calibration seeds
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_cal_core <= DEFAULT_CORE[CORE_W-1:0];
         o_cal_cap <= 8'h00;
         o_cal_bias <= DEFAULT_BIAS[BIAS_W-1:0];
      end else if (quick_q) begin
         o_cal_core <= i_last_core; // [RULE_09]
         o_cal_cap <= i_last_cap;
         o_cal_bias <= i_last_bias;
      end else begin
         o_cal_core <= DEFAULT_CORE[CORE_W-1:0];
         o_cal_cap <= (cap_q > `CAP_MAX) ? `CAP_MAX : cap_q; // [RULE_10]
         o_cal_bias <= DEFAULT_BIAS[BIAS_W-1:0];
      end
   end

   chk_prescale_decode: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_01]
      (i_wr && i_addr == `ADDR_MODE && i_wdata[7:5] == 3'h2) |-> ##2 (o_prescale_ratio == 3'h2))
      else $error("prescale code 2 did not give divide by two");
   chk_prescale_invalid: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_01]
      o_prescale_invalid |-> (o_prescale_ratio == 3'h0))
      else $error("invalid prescale code gave a ratio");
   chk_burst_select: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_02]
      (i_wr && i_addr == `ADDR_MODE && i_wdata[4:2] == 3'b110) |-> ##2 o_sysref_burst)
      else $error("pulse bit in master mode gave no burst");
   chk_master_repeater: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_03]
      !(o_sysref_master && o_sysref_repeater) && !(o_sysref_burst && !o_sysref_master))
      else $error("master and repeater selected together");
   chk_rate_divisor: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_04]
      (i_wr && i_addr == `ADDR_RATE) |-> ##2
      (o_sysref_ratio == {1'b0, $past(i_wdata[10:0], 2), 1'b0} + 13'h0004))
      else $error("sysref ratio is not twice divisor plus four");
   chk_burst_length: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_06]
      (o_sysref_burst_length != 4'h0) |-> o_sysref_burst)
      else $error("burst length shown outside pulser operation");
   chk_channel_division_code_map: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_07]
      (i_wr && i_addr == `ADDR_CHANNEL_DIVISION_CODE && i_wdata[10:6] == 5'h11) |-> ##2
      (o_channel_division_code_ratio == 10'h300 && !o_channel_division_code_reserved))
      else $error("code 17 did not give 768");
   chk_channel_division_code_rsvd: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_07]
      (i_wr && i_addr == `ADDR_CHANNEL_DIVISION_CODE && i_wdata[10:6] >= 5'h12) |-> ##2 o_channel_division_code_reserved)
      else $error("reserved channel code not flagged");
   chk_ramp_gate: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_11]
      $past(!i_ramp_enable) |-> (o_recal_threshold == 33'h0 && !o_recal_due && !o_at_upper))
      else $error("ramp fields acted while ramping off");
   chk_upper_clamp: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_12]
      o_at_upper |-> (o_ramp_offset == $signed(up_q) && $past(i_ramp_offset) > o_ramp_offset))
      else $error("upper limit not held");
   chk_lower_clamp: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_13]
      o_at_lower |-> (o_ramp_offset == $signed(lo_q) && $past(i_ramp_offset) < o_ramp_offset))
      else $error("lower limit not held");
   chk_quick_seed: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_09]
      ($past(quick_q) && $past(i_rst_b)) |-> (o_cal_cap == $past(i_last_cap)))
      else $error("fast recalibration ignored last cap code");
   chk_cap_range: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_10]
      $past(!quick_q) |-> (o_cal_cap <= 8'hB7))
      else $error("start cap code above 183");
   chk_recal_step: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_08]
      o_recal_due |=> !o_recal_due || $past(i_ramp_offset) != $past(i_ramp_offset, 2))
      else $error("recalibration repeated without ramp movement");
   cov_burst_mode: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_sysref_burst);
   cov_upper_hit: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_at_upper);
   cov_recal: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_recal_due);
   cov_read_back: cover property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rd ##1 (o_rdata != 16'h0000));

endmodule

`default_nettype wire

// ===== dv/tb_top.sv
/*
 * self-checking bench for the sysref, channel divider and ramp config bank.
 * assumes the design body holds its own assertions; this bench drives every
 * input directly on the rising edge and never makes the bus wait.
 */
`timescale 1ns/1ps
`include "synth_cfg_defines.svh"
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   synth_cfg_pkg::reg_addr_type i_addr = 7'h00;
   synth_cfg_pkg::reg_word_type i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ramp_enable = 1'b0;
   logic signed [32:0] i_ramp_offset = 33'h0_0000_0000;
   logic [2:0] i_last_core = 3'h0;
   logic [7:0] i_last_cap = 8'h00;
   logic [8:0] i_last_bias = 9'h000;
   logic [15:0] o_rdata;
   logic [2:0] o_prescale_ratio;
   logic o_prescale_invalid, o_sysref_master, o_sysref_repeater, o_sysref_burst;
   logic [3:0] o_sysref_burst_length;
   logic [12:0] o_sysref_ratio;
   logic [23:0] o_delay_weights;
   logic [9:0] o_channel_division_code_ratio;
   logic o_channel_division_code_reserved, o_recal_due, o_at_upper, o_at_lower;
   logic [32:0] o_recal_threshold;
   logic signed [32:0] o_ramp_offset;
   logic [2:0] o_cal_core;
   logic [7:0] o_cal_cap;
   logic [8:0] o_cal_bias;
   int err_total = 0;
   int n_checks = 0;
   logic [15:0] q;
   logic [2:0] m3;
   int cnt;
   // division ratios for channel codes 0 to 17
   localparam logic [9:0] CHTAB [18] = '{10'h002, 10'h004, 10'h006, 10'h008, 10'h00C,
      10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h048, 10'h060, 10'h080, 10'h0C0,
      10'h100, 10'h180, 10'h200, 10'h300};
   localparam int DV [3] = '{0, 5, 2047};
   localparam logic signed [32:0] OFS [4] = '{33'sd2000, -33'sd2000, 33'sd500, -33'sd500};
   localparam logic signed [32:0] CLP [4] = '{33'sd1000, -33'sd1000, 33'sd500, -33'sd500};

   always #20 i_clock = ~i_clock;

   synth_sysref_ramp_config_regs synth_sysref_ramp_config_regs_i (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ramp_enable(i_ramp_enable),
      .i_ramp_offset(i_ramp_offset), .i_last_core(i_last_core), .i_last_cap(i_last_cap),
      .i_last_bias(i_last_bias), .o_prescale_ratio(o_prescale_ratio),
      .o_prescale_invalid(o_prescale_invalid), .o_sysref_master(o_sysref_master),
      .o_sysref_repeater(o_sysref_repeater), .o_sysref_burst(o_sysref_burst),
      .o_sysref_burst_length(o_sysref_burst_length), .o_sysref_ratio(o_sysref_ratio),
      .o_delay_weights(o_delay_weights), .o_channel_division_code_ratio(o_channel_division_code_ratio),
      .o_channel_division_code_reserved(o_channel_division_code_reserved), .o_recal_threshold(o_recal_threshold),
      .o_recal_due(o_recal_due), .o_ramp_offset(o_ramp_offset), .o_at_upper(o_at_upper),
      .o_at_lower(o_at_lower), .o_cal_core(o_cal_core), .o_cal_cap(o_cal_cap),
      .o_cal_bias(o_cal_bias));

   task automatic wr(input synth_cfg_pkg::reg_addr_type a, input synth_cfg_pkg::reg_word_type d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   // read data stand one cycle only, so the zero afterwards is checked here too
   task automatic rd(input synth_cfg_pkg::reg_addr_type a, output logic [15:0] d);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
      @(posedge i_clock);
      #1;
      `CHK(o_rdata, 16'h0000);
   endtask

   // decoded outputs follow one edge after the write edge; settle waits two
   task automatic settle();
      repeat (2) @(posedge i_clock);
      #1;
   endtask

   task automatic ramp(input logic en, input logic signed [32:0] ofs);
      @(posedge i_clock);
      i_ramp_enable <= en;
      i_ramp_offset <= ofs;
      settle();
   endtask

   task automatic due_count(input int n);
      cnt = 0;
      repeat (n) begin
         @(posedge i_clock);
         #1;
         if (o_recal_due === 1'b1) cnt++;
      end
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #(40 * 6000);
      err_total++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge i_clock);
      i_rst_b <= 1'b1;
      settle();
      `CHK(o_prescale_ratio, 3'h4);
      `CHK(o_sysref_ratio, 13'h0004);
      `CHK(o_channel_division_code_ratio, 10'h002);
      `CHK(o_delay_weights, 24'h00003F);
      rd(`ADDR_MODE, q);
      `CHK(q, 16'h0081);
      rd(`ADDR_DLY_A, q);
      `CHK(q, 16'h003F);
      rd(`ADDR_CHANNEL_DIVISION_CODE, q);
      `CHK(q, 16'h0800);
      rd(`ADDR_RECAL, q);
      `CHK(q, 16'h0001);
      wr(7'h60, 16'hFFFF);
      rd(7'h60, q);
      `CHK(q, 16'h0000);
      rd(`ADDR_MODE, q);
      `CHK(q, 16'h0081);
      done("reset and unmapped");
      for (int c = 0; c < 8; c++) begin
         wr(`ADDR_MODE, 16'h0001 | (16'(c) << 5));
         settle();
         `CHK(o_prescale_ratio, (c == 2) ? 3'h2 : (c == 4) ? 3'h4 : 3'h0);
         `CHK(o_prescale_invalid, 1'((c != 2) && (c != 4)));
         rd(`ADDR_MODE, q);
         `CHK(q, 16'h0001 | (16'(c) << 5));
      end
      done("prescale codes");
      // weights three and four share the delay, summing to 63
      wr(`ADDR_DLY_A, 16'h0000);
      wr(`ADDR_DLY_B, {4'hA, 6'h15, 6'h2A});
      for (int m = 0; m < 8; m++) begin
         m3 = 3'(m);
         wr(`ADDR_MODE, 16'h0081 | (16'(m) << 2));
         settle();
         `CHK(o_sysref_master, m3[1] & ~m3[0]);
         `CHK(o_sysref_repeater, m3[1] & m3[0]);
         `CHK(o_sysref_burst, m3[1] & ~m3[0] & m3[2]);
         `CHK(o_sysref_burst_length, (m3 == 3'b110) ? 4'hA : 4'h0);
      end
      `CHK(o_delay_weights, {6'h15, 6'h2A, 12'h000});
      rd(`ADDR_DLY_B, q);
      `CHK(q, {4'hA, 6'h15, 6'h2A});
      done("sysref modes");
      for (int i = 0; i < 3; i++) begin
         wr(`ADDR_RATE, 16'(DV[i]));
         settle();
         `CHK(o_sysref_ratio, 13'(2 * DV[i] + 4));
      end
      done("sysref divisor");
      for (int c = 0; c < 32; c++) begin
         wr(`ADDR_CHANNEL_DIVISION_CODE, 16'h0800 | (16'(c) << 6));
         settle();
         `CHK(o_channel_division_code_ratio, (c < 18) ? CHTAB[c] : 10'h000);
         `CHK(o_channel_division_code_reserved, 1'(c >= 18));
      end
      done("channel divider");
      wr(`ADDR_RECAL, 16'h0801);
      wr(`ADDR_THR_MID, 16'h1234);
      wr(`ADDR_THR_LOW, 16'h5678);
      ramp(1'b1, 33'sd0);
      `CHK(o_recal_threshold, 33'h1_1234_5678);
      ramp(1'b0, 33'sd0);
      `CHK(o_recal_threshold, 33'h0_0000_0000);
      // a start cap code of 200 is out of range and seeds 183
      wr(`ADDR_RECAL, 16'h0191);
      settle();
      `CHK(o_cal_cap, 8'hB7);
      @(posedge i_clock);
      i_last_core <= 3'h5;
      i_last_cap <= 8'h33;
      i_last_bias <= 9'h1AB;
      wr(`ADDR_RECAL, 16'h0021);
      settle();
      `CHK({o_cal_core, o_cal_cap, o_cal_bias}, {3'h0, 8'h10, 9'h000});
      wr(`ADDR_RECAL, 16'h0221);
      settle();
      `CHK({o_cal_core, o_cal_cap, o_cal_bias}, {3'h5, 8'h33, 9'h1AB});
      done("calibration seeds");
      wr(`ADDR_RECAL, 16'h0001);
      wr(`ADDR_THR_MID, 16'h0000);
      wr(`ADDR_THR_LOW, 16'h0064);
      wr(`ADDR_UP_MSB, 16'h0000);
      wr(`ADDR_UP_MID, 16'h0000);
      wr(`ADDR_UP_LOW, 16'h03E8);
      wr(`ADDR_LO_MSB, 16'h0001);
      wr(`ADDR_LO_MID, 16'hFFFF);
      wr(`ADDR_LO_LOW, 16'hFC18);
      rd(`ADDR_LO_LOW, q);
      `CHK(q, 16'hFC18);
      ramp(1'b0, 33'sd0);
      @(posedge i_clock);
      i_ramp_enable <= 1'b1;
      i_ramp_offset <= 33'sd50;
      due_count(5);
      `CHK(cnt, 0);
      @(posedge i_clock);
      i_ramp_offset <= 33'sd150;
      due_count(5);
      `CHK(cnt, 1);
      done("recalibration threshold");
      for (int i = 0; i < 4; i++) begin
         ramp(1'b1, OFS[i]);
         `CHK(o_ramp_offset, CLP[i]);
         `CHK(o_at_upper, 1'(i == 0));
         `CHK(o_at_lower, 1'(i == 1));
      end
      ramp(1'b0, 33'sd2000);
      `CHK(o_ramp_offset, 33'sd2000);
      `CHK({o_at_upper, o_at_lower}, 2'b00);
      ramp(1'b0, -33'sd2000);
      `CHK(o_ramp_offset, -33'sd2000);
      done("ramp limits");
      close_out();
   end
endmodule

`default_nettype wire
